// ==== design/sep_pkg.sv ====
package sep_pkg;

    // Core clock and the select low time the status path checks against
    localparam int CLK_PERIOD_NS = 10;
    localparam int SEL_LOW_TIME_NS = 250;
    localparam int SEL_LOW_CYC = (SEL_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Self-timed programming duration (round down, it is a longest time)
    localparam int PROG_TIME_NS = 2000000;
    localparam int PROG_CYC = PROG_TIME_NS / CLK_PERIOD_NS;

    // Frame layout after the start bit
    localparam logic [4:0] OP_BITS = 5'h02;
    localparam logic [4:0] ADDR_BITS_X8 = 5'h09;
    localparam logic [4:0] ADDR_BITS_X16 = 5'h08;
    localparam logic [4:0] DATA_BITS_X8 = 5'h08;
    localparam logic [4:0] DATA_BITS_X16 = 5'h10;
    localparam int MEM_BYTES = 512;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // Word width source: the pin, or a fixed variant
    localparam int ORG_PIN = 0;
    localparam int ORG_FIXED_X8 = 1;
    localparam int ORG_FIXED_X16 = 2;

    // Sub-codes of the extended opcode, taken from the two top address bits
    localparam logic [1:0] EXT_DISABLE = 2'h0;
    localparam logic [1:0] EXT_ENABLE = 2'h3;

    // Indices into the clock-crossing synchroniser vector
    localparam int SYNC_W = 4;
    localparam int SYNC_CS = 0;
    localparam int SYNC_CMD = 1;
    localparam int SYNC_SHIFT = 2;
    localparam int SYNC_START = 3;

    typedef enum logic [1:0] {
        SEP_OP_EXT = 2'b00,
        SEP_OP_WRITE = 2'b01,
        SEP_OP_READ = 2'b10,
        SEP_OP_ERASE = 2'b11
    } sep_op_e;

    typedef enum logic [2:0] {
        LK_IDLE = 3'b000,
        LK_CMD = 3'b001,
        LK_DATA = 3'b010,
        LK_READ = 3'b011,
        LK_DONE = 3'b100
    } sep_link_e;

    typedef struct packed {
        sep_op_e op;
        logic wide;
        logic [8:0] addr;
        logic [15:0] data;
    } sep_cmd_s;

endpackage : sep_pkg

// ==== design/sep_cmd_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
module sep_cmd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] slot_reg [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic [AW:0] count;

    // Extra pointer bit tells full from empty without a separate flag
    assign count = wr_ptr_reg - rd_ptr_reg;
    assign in_ready = (count != FULL_COUNT);
    assign out_valid = (count != '0);
    assign out_data = slot_reg[rd_ptr_reg[AW-1:0]];

    // Pointers move only on a completed handshake
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else if (clk_en)
        begin
            if (in_valid && in_ready)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (out_valid && out_ready)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end

    // Storage needs no reset; nothing reads an empty slot
    always_ff @(posedge clk)
    begin
        if (clk_en && in_valid && in_ready)
            slot_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end

endmodule : sep_cmd_fifo
`default_nettype wire

// ==== design/sep_eeprom_core.sv ====
// Behaviour
// - Read data shifts out after rising clock
// - Status shown when select rises after low
// - Select low throughout: output stays high impedance
// - Status after completion reads high (ready)
// - Start bit then select low clears status
// - Width select high gives 16-bit words
// - Width select low gives 8-bit words
// - Fixed variants use fixed word width
// - Status low busy, high ready
// - Select low time met; low resets control
// - Read starts with dummy zero bit
// - Input bits captured on rising clock edge
`timescale 1ns/10ps
`default_nettype none
module sep_eeprom_core #(
    parameter int ORG_MODE = sep_pkg::ORG_PIN,
    parameter int PROG_CYCLES = sep_pkg::PROG_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic serial_clk,
    input wire logic chip_select,
    input wire logic serial_input_line,
    input wire logic word_width_select,
    output logic serial_output_line,
    output logic serial_output_oe_n
);
    localparam int BUSY_W = $clog2(PROG_CYCLES + 1);
    localparam logic [BUSY_W-1:0] PROG_LOAD = BUSY_W'(PROG_CYCLES);
    localparam logic [4:0] SEL_LOW_LIM = 5'(sep_pkg::SEL_LOW_CYC);

    // ---------------- Link domain (serial_clk) ----------------
    sep_pkg::sep_link_e lk_state_reg;
    logic [25:0] lk_sr_reg;
    logic [4:0] lk_cnt_reg;
    sep_pkg::sep_op_e lk_op_reg;
    logic [8:0] lk_addr_reg;
    logic lk_start_reg;
    logic org_meta_reg;
    logic org_sync_reg;
    logic lk_cmd_tgl_reg;
    logic lk_shift_tgl_reg;
    sep_pkg::sep_cmd_s lk_cmd_reg;

    logic lk_wide;
    logic [25:0] lk_shift;
    logic [4:0] cmd_len;
    logic [4:0] data_len;
    sep_pkg::sep_op_e op_now;
    logic [8:0] addr_now;
    logic cmd_last;
    logic data_last;
    logic send_now;
    sep_pkg::sep_cmd_s send_cmd;

    // Width select is a static strap; two flops before the link logic uses it
    always_ff @(posedge serial_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            org_meta_reg <= 1'b0;
            org_sync_reg <= 1'b0;
        end
        else
        begin
            org_meta_reg <= word_width_select;
            org_sync_reg <= org_meta_reg;
        end
    end

    // Word width and frame field positions
    always_comb
    begin
        if (ORG_MODE == sep_pkg::ORG_FIXED_X16)
            lk_wide = 1'b1;
        else if (ORG_MODE == sep_pkg::ORG_FIXED_X8)
            lk_wide = 1'b0;
        else
            lk_wide = org_sync_reg;
        lk_shift = {lk_sr_reg[24:0], serial_input_line};
        cmd_len = sep_pkg::OP_BITS + (lk_wide ? sep_pkg::ADDR_BITS_X16 : sep_pkg::ADDR_BITS_X8);
        data_len = lk_wide ? sep_pkg::DATA_BITS_X16 : sep_pkg::DATA_BITS_X8;
        op_now = sep_pkg::sep_op_e'(lk_wide ? lk_shift[9:8] : lk_shift[10:9]);
        addr_now = lk_wide ? {1'b0, lk_shift[7:0]} : lk_shift[8:0];
        cmd_last = (lk_state_reg == sep_pkg::LK_CMD) && (lk_cnt_reg == cmd_len - 5'h01);
        data_last = (lk_state_reg == sep_pkg::LK_DATA) && (lk_cnt_reg == data_len - 5'h01);
        send_now = (cmd_last && op_now != sep_pkg::SEP_OP_WRITE) || data_last;
        send_cmd.op = cmd_last ? op_now : lk_op_reg;
        send_cmd.wide = lk_wide;
        send_cmd.addr = cmd_last ? addr_now : lk_addr_reg;
        send_cmd.data = lk_wide ? lk_shift[15:0] : {8'h00, lk_shift[7:0]};
    end

    // Frame decoder; select low holds it in reset
    always_ff @(posedge serial_clk or negedge chip_select)
    begin
        if (!chip_select)
        begin
            lk_state_reg <= sep_pkg::LK_IDLE;
            lk_sr_reg <= '0;
            lk_cnt_reg <= '0;
            lk_op_reg <= sep_pkg::SEP_OP_EXT;
            lk_addr_reg <= '0;
            lk_start_reg <= 1'b0;
        end
        else
        begin
            unique case (lk_state_reg)
                sep_pkg::LK_IDLE:
                begin
                    // Zeros before the start bit are ignored
                    if (serial_input_line)
                    begin
                        lk_state_reg <= sep_pkg::LK_CMD;
                        lk_start_reg <= 1'b1;
                        lk_cnt_reg <= '0;
                    end
                end
                sep_pkg::LK_CMD:
                begin
                    lk_sr_reg <= lk_shift;
                    lk_cnt_reg <= lk_cnt_reg + 5'h01;
                    if (cmd_last)
                    begin
                        lk_op_reg <= op_now;
                        lk_addr_reg <= addr_now;
                        lk_cnt_reg <= '0;
                        if (op_now == sep_pkg::SEP_OP_READ)
                            lk_state_reg <= sep_pkg::LK_READ;
                        else if (op_now == sep_pkg::SEP_OP_WRITE)
                            lk_state_reg <= sep_pkg::LK_DATA;
                        else
                            lk_state_reg <= sep_pkg::LK_DONE;
                    end
                end
                sep_pkg::LK_DATA:
                begin
                    lk_sr_reg <= lk_shift;
                    lk_cnt_reg <= lk_cnt_reg + 5'h01;
                    if (data_last)
                        lk_state_reg <= sep_pkg::LK_DONE;
                end
                sep_pkg::LK_READ, sep_pkg::LK_DONE:
                begin
                    lk_state_reg <= lk_state_reg;
                end
                default:
                begin
                    lk_state_reg <= sep_pkg::LK_IDLE;
                end
            endcase
        end
    end

    // Toggles survive select low, else a reset would fake an event
    always_ff @(posedge serial_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lk_cmd_tgl_reg <= 1'b0;
            lk_shift_tgl_reg <= 1'b0;
            lk_cmd_reg <= '0;
        end
        else
        begin
            if (send_now)
            begin
                lk_cmd_reg <= send_cmd;
                lk_cmd_tgl_reg <= ~lk_cmd_tgl_reg;
            end
            if (lk_state_reg == sep_pkg::LK_READ)
                lk_shift_tgl_reg <= ~lk_shift_tgl_reg;
        end
    end

    // ---------------- Core domain (clk) ----------------
    logic rst_meta_reg;
    logic rst_n_sync;
    logic [sep_pkg::SYNC_W-1:0] sync_in;
    logic [sep_pkg::SYNC_W-1:0] sync_meta_reg;
    logic [sep_pkg::SYNC_W-1:0] sync_reg;
    logic [sep_pkg::SYNC_W-1:0] sync_d_reg;
    logic cs_s;
    logic cs_rise;
    logic cs_fall;
    logic cmd_evt;
    logic shift_evt;
    logic start_rise;

    // Reset release through two flops
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_sync <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_sync <= rst_meta_reg;
        end
    end

    // Levels and toggles from the pins and the link domain
    assign sync_in = {lk_start_reg, lk_shift_tgl_reg, lk_cmd_tgl_reg, chip_select};

    generate
        for (genvar i = 0; i < sep_pkg::SYNC_W; i++)
        begin : g_sync
            always_ff @(posedge clk or negedge rst_n_sync)
            begin
                if (!rst_n_sync)
                begin
                    sync_meta_reg[i] <= 1'b0;
                    sync_reg[i] <= 1'b0;
                    sync_d_reg[i] <= 1'b0;
                end
                else if (clk_en)
                begin
                    sync_meta_reg[i] <= sync_in[i];
                    sync_reg[i] <= sync_meta_reg[i];
                    sync_d_reg[i] <= sync_reg[i];
                end
            end
        end
    endgenerate

    assign cs_s = sync_reg[sep_pkg::SYNC_CS];
    assign cs_rise = cs_s && !sync_d_reg[sep_pkg::SYNC_CS];
    assign cs_fall = !cs_s && sync_d_reg[sep_pkg::SYNC_CS];
    assign cmd_evt = sync_reg[sep_pkg::SYNC_CMD] ^ sync_d_reg[sep_pkg::SYNC_CMD];
    assign shift_evt = sync_reg[sep_pkg::SYNC_SHIFT] ^ sync_d_reg[sep_pkg::SYNC_SHIFT];
    assign start_rise = sync_reg[sep_pkg::SYNC_START] && !sync_d_reg[sep_pkg::SYNC_START];

    logic pend_valid_reg;
    sep_pkg::sep_cmd_s pend_cmd_reg;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [$bits(sep_pkg::sep_cmd_s)-1:0] buf_out_data;
    sep_pkg::sep_cmd_s exe_cmd;
    logic [BUSY_W-1:0] busy_cnt_reg;
    logic busy;
    logic pop;
    logic prog_go;
    logic [1:0] ext_code;

    // The link word is stable for a whole serial period after its toggle
    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            pend_valid_reg <= 1'b0;
            pend_cmd_reg <= '0;
        end
        else if (clk_en)
        begin
            if (cmd_evt)
            begin
                pend_valid_reg <= 1'b1;
                pend_cmd_reg <= lk_cmd_reg;
            end
            else if (pend_valid_reg && buf_in_ready)
                pend_valid_reg <= 1'b0;
        end
    end

    // Commands wait here while a programming cycle runs
    sep_cmd_fifo #(
        .WIDTH($bits(sep_pkg::sep_cmd_s)),
        .DEPTH(2)
    ) u_cmd_fifo (
        .clk(clk),
        .rst_n(rst_n_sync),
        .clk_en(clk_en),
        .in_valid(pend_valid_reg),
        .in_ready(buf_in_ready),
        .in_data(pend_cmd_reg),
        .out_valid(buf_out_valid),
        .out_ready(!busy),
        .out_data(buf_out_data)
    );

    assign exe_cmd = sep_pkg::sep_cmd_s'(buf_out_data);
    assign busy = (busy_cnt_reg != '0);
    assign pop = buf_out_valid && !busy;
    assign ext_code = exe_cmd.wide ? exe_cmd.addr[7:6] : exe_cmd.addr[8:7];

    logic write_en_reg;
    logic [7:0] mem_reg [sep_pkg::MEM_BYTES];

    assign prog_go = pop && write_en_reg &&
        (exe_cmd.op == sep_pkg::SEP_OP_WRITE || exe_cmd.op == sep_pkg::SEP_OP_ERASE);

    // Programming is refused until an enable command arrives
    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
            write_en_reg <= 1'b0;
        else if (clk_en && pop && exe_cmd.op == sep_pkg::SEP_OP_EXT)
        begin
            if (ext_code == sep_pkg::EXT_ENABLE)
                write_en_reg <= 1'b1;
            else if (ext_code == sep_pkg::EXT_DISABLE)
                write_en_reg <= 1'b0;
        end
    end

    // Array update; the busy timer stands for the cell programming time
    always_ff @(posedge clk)
    begin
        if (clk_en && prog_go)
        begin
            if (exe_cmd.wide)
            begin
                mem_reg[{exe_cmd.addr[7:0], 1'b0}] <= (exe_cmd.op == sep_pkg::SEP_OP_ERASE) ?
                    sep_pkg::ERASED_BYTE : exe_cmd.data[15:8];
                mem_reg[{exe_cmd.addr[7:0], 1'b1}] <= (exe_cmd.op == sep_pkg::SEP_OP_ERASE) ?
                    sep_pkg::ERASED_BYTE : exe_cmd.data[7:0];
            end
            else
                mem_reg[exe_cmd.addr] <= (exe_cmd.op == sep_pkg::SEP_OP_ERASE) ?
                    sep_pkg::ERASED_BYTE : exe_cmd.data[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
            busy_cnt_reg <= '0;
        else if (clk_en)
        begin
            if (prog_go)
                busy_cnt_reg <= PROG_LOAD;
            else if (busy)
                busy_cnt_reg <= busy_cnt_reg - 1'b1;
        end
    end

    // Status display bookkeeping
    logic [4:0] low_cnt_reg;
    logic armed_reg;
    logic clr_req_reg;
    logic show_reg;

    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            low_cnt_reg <= '0;
            armed_reg <= 1'b0;
            clr_req_reg <= 1'b0;
            show_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            // Saturating count of select low time
            if (!cs_s)
                low_cnt_reg <= (low_cnt_reg == SEL_LOW_LIM) ? low_cnt_reg : low_cnt_reg + 5'h01;
            else
                low_cnt_reg <= '0;
            // A start bit that does not end in programming asks to drop status
            if (prog_go || cs_fall)
                clr_req_reg <= 1'b0;
            else if (start_rise)
                clr_req_reg <= 1'b1;
            // New programming wins over a clear in the same cycle
            if (prog_go)
                armed_reg <= 1'b1;
            else if (cs_fall && clr_req_reg)
                armed_reg <= 1'b0;
            if (!cs_s || (cs_fall && clr_req_reg))
                show_reg <= 1'b0;
            else if (cs_rise && armed_reg && low_cnt_reg >= SEL_LOW_LIM)
                show_reg <= 1'b1;
        end
    end

    // Read shifter: dummy zero first, then words MSB first, address rolls on
    logic read_active_reg;
    logic [8:0] rd_addr_reg;
    logic [15:0] rd_sh_reg;
    logic [4:0] rd_cnt_reg;
    logic rd_wide_reg;
    logic rd_bit_reg;
    logic [8:0] rd_next;

    function automatic logic [15:0] word_at(input logic [8:0] addr, input logic wide);
        if (wide)
            return {mem_reg[{addr[7:0], 1'b0}], mem_reg[{addr[7:0], 1'b1}]};
        else
            return {mem_reg[addr], 8'h00};
    endfunction : word_at

    assign rd_next = rd_wide_reg ? {1'b0, rd_addr_reg[7:0] + 8'h01} : rd_addr_reg + 9'h001;

    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            read_active_reg <= 1'b0;
            rd_addr_reg <= '0;
            rd_sh_reg <= '0;
            rd_cnt_reg <= '0;
            rd_wide_reg <= 1'b0;
            rd_bit_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (pop && exe_cmd.op == sep_pkg::SEP_OP_READ)
            begin
                read_active_reg <= 1'b1;
                rd_addr_reg <= exe_cmd.addr;
                rd_wide_reg <= exe_cmd.wide;
                rd_sh_reg <= word_at(exe_cmd.addr, exe_cmd.wide);
                rd_cnt_reg <= '0;
                rd_bit_reg <= 1'b0;
            end
            else if (!cs_s)
                read_active_reg <= 1'b0;
            else if (shift_evt && read_active_reg)
            begin
                rd_bit_reg <= rd_sh_reg[15];
                if (rd_cnt_reg == (rd_wide_reg ? sep_pkg::DATA_BITS_X16 : sep_pkg::DATA_BITS_X8) - 5'h01)
                begin
                    rd_addr_reg <= rd_next;
                    rd_sh_reg <= word_at(rd_next, rd_wide_reg);
                    rd_cnt_reg <= '0;
                end
                else
                begin
                    rd_sh_reg <= {rd_sh_reg[14:0], 1'b0};
                    rd_cnt_reg <= rd_cnt_reg + 5'h01;
                end
            end
        end
    end

    // Pin driver; sync latency is the output delay after the serial edge
    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            serial_output_line <= 1'b1;
            serial_output_oe_n <= 1'b1;
        end
        else if (clk_en)
        begin
            if (cs_s && read_active_reg)
            begin
                serial_output_line <= rd_bit_reg;
                serial_output_oe_n <= 1'b0;
            end
            else if (cs_s && show_reg)
            begin
                serial_output_line <= !busy;
                serial_output_oe_n <= 1'b0;
            end
            else
            begin
                serial_output_line <= 1'b1;
                serial_output_oe_n <= 1'b1;
            end
        end
    end

endmodule : sep_eeprom_core
`default_nettype wire

// ==== tb/sep_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module sep_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic serial_clk,
    input wire logic chip_select,
    input wire logic serial_input_line,
    input wire logic word_width_select,
    input wire logic serial_output_line,
    input wire logic serial_output_oe_n
);
    logic [5:0] low_cnt_reg;

    // Deselected cycles, saturating so a long idle cannot wrap to a short one
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            low_cnt_reg <= 6'h00;
        else if (chip_select)
            low_cnt_reg <= 6'h00;
        else if (low_cnt_reg != 6'h3f)
            low_cnt_reg <= low_cnt_reg + 6'h01;
    end

    // Long deselect, and a driven pin while the link clock rests low
    sequence s_long_low;
        !chip_select [*8];
    endsequence
    sequence s_quiet_drive;
        (chip_select && !serial_clk && !serial_output_oe_n) [*2];
    endsequence

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    AST_RST_IDLE: assert property ($rose(reset_n) |-> serial_output_oe_n && serial_output_line)
        else $error("pin driven right after reset");
    AST_IDLE_HIGH: assert property (serial_output_oe_n |-> serial_output_line)
        else $error("line low while released");
    AST_DESEL_HIZ: assert property (s_long_low |-> serial_output_oe_n)
        else $error("pin driven while deselected");
    AST_DRIVE_SELECTED: assert property ($fell(serial_output_oe_n) |-> chip_select)
        else $error("drive began while deselected");
    AST_HOLD_IN_FRAME: assert property ((chip_select && !serial_output_oe_n) ##1 chip_select |-> !serial_output_oe_n)
        else $error("pin released while selected");
    AST_RELEASE_CAUSE: assert property ($rose(serial_output_oe_n) |-> !chip_select)
        else $error("release without deselect");
    // Threshold sits 5 cycles under the limit to absorb select sampling skew
    AST_SHORT_LOW: assert property ($rose(chip_select) && low_cnt_reg < 6'h14 |-> serial_output_oe_n [*6])
        else $error("status shown after short deselect");
    AST_NO_FALL: assert property (s_quiet_drive |-> !$fell(serial_output_line))
        else $error("line fell with link clock low");
endmodule : sep_chk

bind sep_eeprom_core sep_chk u_chk (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .serial_clk(serial_clk),
    .chip_select(chip_select), .serial_input_line(serial_input_line), .word_width_select(word_width_select),
    .serial_output_line(serial_output_line), .serial_output_oe_n(serial_output_oe_n));
`default_nettype wire

// ==== tb/sep_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module sep_host_model (
    output logic serial_clk,
    output logic chip_select,
    output logic serial_input_line,
    input wire logic serial_output_line,
    input wire logic serial_output_oe_n
);
    // Pin as the host sees it: it floats once the device lets go
    wire do_pin = serial_output_oe_n ? 1'bz : serial_output_line;

    // Link idle; its clock stands still outside frames except during pulse
    initial
    begin
        serial_clk = 1'b0;
        chip_select = 1'b0;
        serial_input_line = 1'b0;
    end

    // Deselect for a span; low deselect also resets the device's decoder
    task automatic sel_low(input int ns);
        chip_select = 1'b0;
        #(ns);
    endtask : sel_low

    // Edges with the device deselected, to load its width synchroniser
    task automatic pulse(input int n);
        repeat (n)
        begin
            #80 serial_clk = 1'b1;
            #80 serial_clk = 1'b0;
        end
    endtask : pulse

    // Send n bits MSB first, then collect dummy plus nrd bits before each fall
    task automatic xfer(input logic [31:0] bits, input int n, input int nrd, output logic [16:0] rd);
        rd = 17'h00000;
        chip_select = 1'b1;
        #103;
        for (int i = 0; i < n + nrd; i++)
        begin
            serial_input_line = (i < n) ? bits[n-1-i] : ~serial_input_line;
            #80 serial_clk = 1'b1;
            #75 if (i >= n - 1 && nrd > 0) rd = {rd[15:0], do_pin};
            #5 serial_clk = 1'b0;
        end
    endtask : xfer

    // Select and look at the pin without clocking
    task automatic status(output logic v);
        chip_select = 1'b1;
        #100 v = do_pin;
    endtask : status
endmodule : sep_host_model
`default_nettype wire

// ==== tb/test_serial_eeprom_status_and_width.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_serial_eeprom_status_and_width;
    logic clk;
    logic reset_n;
    logic wws;
    logic en;
    logic v;
    logic [16:0] rd;
    int fails;
    int num_checks;
    wire logic sclk;
    wire logic cs;
    wire logic sdi;
    wire logic sdo;
    wire logic oe_n;
    wire logic sdo2;
    wire logic oe2_n;

    // Short programming time keeps the run brief
    sep_eeprom_core #(.ORG_MODE(sep_pkg::ORG_PIN), .PROG_CYCLES(200)) dut (.clk(clk), .reset_n(reset_n),
        .clk_en(en), .serial_clk(sclk), .chip_select(cs), .serial_input_line(sdi),
        .word_width_select(wws), .serial_output_line(sdo), .serial_output_oe_n(oe_n));
    // Fixed x16 variant, strap held opposite so only the fixed width decodes
    sep_eeprom_core #(.ORG_MODE(sep_pkg::ORG_FIXED_X16), .PROG_CYCLES(200)) dut_fixed (.clk(clk), .reset_n(reset_n),
        .clk_en(en), .serial_clk(sclk), .chip_select(cs), .serial_input_line(sdi),
        .word_width_select(!wws), .serial_output_line(sdo2), .serial_output_oe_n(oe2_n));
    sep_host_model host (.serial_clk(sclk), .chip_select(cs), .serial_input_line(sdi),
        .serial_output_line(sdo), .serial_output_oe_n(oe_n));

    // Core clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [16:0] seen, input logic [16:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    // One instruction after a full deselect
    task automatic cmd(input logic [31:0] b, input int n, input int nrd);
        host.sel_low(300);
        host.xfer(b, n, nrd, rd);
    endtask : cmd

    // Wait out programming, see ready, then clear status with a start bit
    task automatic done();
        host.sel_low(2800);
        host.status(v);
        chk("ready", v, 1'b1);
        host.xfer(32'h1, 1, 0, rd);
    endtask : done

    task automatic t_refused();
        cmd({3'b101, 8'h12, 16'ha5c3}, 27, 0);
        host.sel_low(300);
        host.status(v);
        chk("no status", v, 1'bz);
    endtask : t_refused

    task automatic t_write_status();
        cmd({3'b100, 8'hc0}, 11, 0);
        cmd({3'b101, 8'h12, 16'ha5c3}, 27, 0);
        host.sel_low(300);
        host.status(v);
        chk("busy", v, 1'b0);
        chk("fixed x16 busy", {oe2_n, sdo2}, 2'b00);
        done();
        host.sel_low(300);
        host.status(v);
        chk("cleared", v, 1'bz);
        cmd({3'b110, 8'h12}, 11, 16);
        chk("x16 read", rd, 17'h0a5c3);
    endtask : t_write_status

    task automatic t_hold_low();
        cmd({3'b101, 8'h13, 16'h0ff0}, 27, 0);
        host.sel_low(1000);
        chk("hiz held low", host.do_pin, 1'bz);
        // Frozen core: the busy timer must not run while enable is low
        @(posedge clk) #1 en = 1'b0;
        host.sel_low(2000);
        @(posedge clk) #1 en = 1'b1;
        host.status(v);
        chk("frozen busy", v, 1'b0);
        host.sel_low(2000);
        host.status(v);
        chk("ready late", v, 1'b1);
        host.xfer(32'h1, 1, 0, rd);
        cmd({3'b101, 8'h14, 16'h1234}, 27, 0);
        host.sel_low(150);
        host.status(v);
        chk("short low", v, 1'bz);
        done();
    endtask : t_hold_low

    task automatic t_width8();
        host.sel_low(300);
        wws = 1'b0;
        host.pulse(3);
        cmd({3'b110, 9'h024}, 12, 8);
        chk("x8 high byte", rd, 17'h000a5);
        cmd({3'b111, 9'h025}, 12, 0);
        done();
        cmd({3'b110, 9'h025}, 12, 8);
        chk("x8 erased", rd, 17'h000ff);
        cmd({3'b101, 9'h026, 8'h3c}, 20, 0);
        done();
        cmd({3'b110, 9'h026}, 12, 8);
        chk("x8 write", rd, 17'h0003c);
    endtask : t_width8

    // Main sequence
    initial
    begin
        reset_n = 1'b0;
        wws = 1'b1;
        en = 1'b1;
        fails = 0;
        num_checks = 0;
        repeat (2) @(posedge clk);
        #1 reset_n = 1'b1;
        host.pulse(3);
        t_refused();
        t_write_status();
        t_hold_low();
        t_width8();
        conclude();
    end

    // Watchdog, well beyond the expected run of about 63 us
    initial
    begin
        #400000;
        fails++;
        conclude();
    end
endmodule : test_serial_eeprom_status_and_width
`default_nettype wire
